// >>> include/rcc_consts.svh
// Purpose: Constants for the custom command handler
// Assumes: 100 MHz clock
// Notes: Codes, error values and field sizes
`ifndef RCC_CONSTS_SVH
`define RCC_CONSTS_SVH
`define RCC_OP_WR_EXT 16'hA51F
`define RCC_OP_SEND_CMD 16'hA61F
`define RCC_OP_ADDR_CMD 16'hA71F
`define RCC_OP_WR_STAT 16'hA81F
`define RCC_OP_RD_STAT 16'hA91F
`define RCC_OP_LOCK_DEV 16'hB01F
`define RCC_OP_UNLOCK_DEV 16'hB11F
`define RCC_OP_UPD_RF 16'hC01F
`define RCC_OP_LOCK_PG 16'hD01F
`define RCC_OP_UNLOCK_PG 16'hD11F
`define RCC_ERR_NOT_SUPP 8'h01
`define RCC_ERR_FORMAT 8'h02
`define RCC_ERR_OPTION 8'h03
`define RCC_ERR_UNKNOWN 8'h0F
`define RCC_ERR_NO_BLOCK 8'h10
`define RCC_ERR_ALR_LOCKED 8'h11
`define RCC_ERR_BLK_LOCKED 8'h12
`define RCC_ERR_DEV_LOCKED 8'hA0
`define RCC_ERR_BUSY 8'hA1
`define RCC_ERR_DENIED 8'hA2
`define RCC_PAGES 8
`define RCC_FLAGS_OK 8'h00
`define RCC_FLAGS_ERR 8'h01
`define RCC_FLAGS_OPT_BIT 6
`endif

// >>> include/rcc_pkg.sv
// Purpose: Types for the custom command handler
// Assumes: Constants header included by users
// Notes: SPI request kinds
package rcc_pkg;
	typedef enum logic [2:0] {
		RCC_SPI_NONE,
		RCC_SPI_WRITE,
		RCC_SPI_OPCODE,
		RCC_SPI_ADDR,
		RCC_SPI_WSTAT,
		RCC_SPI_RSTAT
	} rcc_spi_kind_e;
endpackage : rcc_pkg

// >>> include/rcc_spi_if.sv
// Purpose: Link from command core to SPI launcher
// Assumes: One clock
// Notes: Start pulse with fields, done pulse with byte
`timescale 1ns/1ps
interface rcc_spi_if;
	import rcc_pkg::*;
	logic start;
	rcc_spi_kind_e kind;
	logic [7:0] opcode;
	logic [15:0] addr;
	logic [15:0] data;
	logic busy;
	logic done;
	logic [7:0] rdata;
	modport core (output start, output kind, output opcode, output addr, output data,
		input busy, input done, input rdata);
	modport launch (input start, input kind, input opcode, input addr, input data,
		output busy, output done, output rdata);
endinterface : rcc_spi_if

// >>> src/rcc_spi_launch.sv
// Purpose: Hands SPI requests to the external SPI engine
// Assumes: Engine takes a request on spi_req and answers on spi_done
// Notes: Holds request until the engine finishes
`timescale 1ns/1ps
module rcc_spi_launch
	import rcc_pkg::*;
(
	input wire logic clk,
	input wire logic reset,
	rcc_spi_if.launch link,
	output logic spi_req,
	output rcc_spi_kind_e spi_kind,
	output logic [7:0] spi_opcode,
	output logic [15:0] spi_addr,
	output logic [15:0] spi_wdata,
	input wire logic spi_done,
	input wire logic [7:0] spi_rdata
);
	typedef struct packed {
		logic req;
		rcc_spi_kind_e kind;
		logic [7:0] opcode;
		logic [15:0] addr;
		logic [15:0] data;
		logic done;
		logic [7:0] rdata;
	} rcc_launch_s;
	rcc_launch_s st;
	rcc_launch_s next_st;
	always_comb begin
		next_st = st;
		next_st.done = 1'b0;
		if (!st.req && link.start) begin
			next_st.req = 1'b1;
			next_st.kind = link.kind;
			next_st.opcode = link.opcode;
			next_st.addr = link.addr;
			next_st.data = link.data;
		end else if (st.req && spi_done) begin
			next_st.req = 1'b0;
			next_st.done = 1'b1;
			next_st.rdata = spi_rdata;
		end
	end
	always_ff @(posedge clk) begin
		if (reset) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end
	assign spi_req = st.req;
	assign spi_kind = st.kind;
	assign spi_opcode = st.opcode;
	assign spi_addr = st.addr;
	assign spi_wdata = st.data;
	assign link.busy = st.req;
	assign link.done = st.done;
	assign link.rdata = st.rdata;
endmodule : rcc_spi_launch

// >>> src/rcc_cmd_handler.sv
// Purpose: Decodes and executes custom contactless commands
// Assumes: Frame already parsed into fields, CRC checked upstream
// Notes: One request at a time; answer is a pulse with flags, code, data
`timescale 1ns/1ps
`include "rcc_consts.svh"
////////////////////////////////////////////////////////////////////////////////
module rcc_cmd_handler
	import rcc_pkg::*;
(
	input wire logic clk,
	input wire logic reset,
	input wire logic req_valid,
	input wire logic [15:0] req_code,
	input wire logic [7:0] req_flags,
	input wire logic req_crc_ok,
	input wire logic req_format_ok,
	input wire logic [15:0] req_addr,
	input wire logic [15:0] req_data,
	input wire logic [7:0] req_opcode,
	input wire logic [7:0] req_page,
	input wire logic [15:0] req_password,
	input wire logic [15:0] eeprom_password,
	input wire logic core_lock,
	input wire logic ext_mem_present,
	input wire logic ext_addr_denied,
	input wire logic ext_block_locked,
	input wire logic dma_busy,
	input wire logic dma_done,
	output logic dma_start,
	output logic device_locked,
	output logic [`RCC_PAGES-1:0] page_locked,
	output logic req_pending,
	output logic resp_valid,
	output logic [7:0] resp_flags,
	output logic [7:0] resp_error,
	output logic resp_has_data,
	output logic [7:0] resp_data,
	output logic spi_req,
	output rcc_spi_kind_e spi_kind,
	output logic [7:0] spi_opcode,
	output logic [15:0] spi_addr,
	output logic [15:0] spi_wdata,
	input wire logic spi_done,
	input wire logic [7:0] spi_rdata
);
	typedef enum logic [1:0] {
		RCC_IDLE,
		RCC_SPI_WAIT,
		RCC_DMA_WAIT
	} rcc_state_e;
	typedef struct packed {
		rcc_state_e state;
		logic locked;
		logic [`RCC_PAGES-1:0] pages;
		logic dma_go;
		logic spi_write;
		logic resp_v;
		logic [7:0] flags;
		logic [7:0] err;
		logic has_data;
		logic [7:0] data;
	} rcc_core_s;
	rcc_core_s st;
	rcc_core_s next_st;
	rcc_spi_if link ();
	logic launch_start;
	rcc_spi_kind_e launch_kind;
	logic page_ok;
	logic [2:0] page_idx;
	logic pw_ok;
	logic opt_bad;
	assign page_idx = req_page[2:0];
	////////////////////////////////////////////////////////////////////////////////
	// page range check
	assign page_ok = (req_page < 8'(`RCC_PAGES));
	assign pw_ok = (req_password == eeprom_password);
	assign opt_bad = req_flags[`RCC_FLAGS_OPT_BIT];
	// Shorthand for error answer
	function automatic rcc_core_s fail(input rcc_core_s s, input logic [7:0] code);
		rcc_core_s r;
		r = s;
		r.resp_v = 1'b1;
		r.flags = `RCC_FLAGS_ERR;
		r.err = code;
		r.has_data = 1'b0;
		return r;
	endfunction : fail
	function automatic rcc_core_s pass(input rcc_core_s s);
		rcc_core_s r;
		r = s;
		r.resp_v = 1'b1;
		r.flags = `RCC_FLAGS_OK;
		r.err = 8'h00;
		r.has_data = 1'b0;
		return r;
	endfunction : pass
	////////////////////////////////////////////////////////////////////////////////
	always_comb begin
		next_st = st;
		next_st.resp_v = 1'b0;
		next_st.dma_go = 1'b0;
		launch_start = 1'b0;
		launch_kind = RCC_SPI_NONE;
		unique case (st.state)
			RCC_IDLE: begin
				if (req_valid && req_crc_ok) begin
					unique case (req_code)
						`RCC_OP_WR_EXT, `RCC_OP_SEND_CMD, `RCC_OP_ADDR_CMD,
						`RCC_OP_WR_STAT, `RCC_OP_RD_STAT: begin
							unique case (req_code)
								`RCC_OP_WR_EXT: launch_kind = RCC_SPI_WRITE;
								`RCC_OP_SEND_CMD: launch_kind = RCC_SPI_OPCODE;
								`RCC_OP_ADDR_CMD: launch_kind = RCC_SPI_ADDR;
								`RCC_OP_WR_STAT: launch_kind = RCC_SPI_WSTAT;
								default: launch_kind = RCC_SPI_RSTAT;
							endcase
							if (!req_format_ok) begin
								next_st = fail(st, `RCC_ERR_FORMAT);
							end else if (opt_bad) begin
								next_st = fail(st, `RCC_ERR_OPTION);
							end else if (!ext_mem_present) begin
								next_st = fail(st, `RCC_ERR_NO_BLOCK);
							end else if (st.locked) begin
								next_st = fail(st, `RCC_ERR_DEV_LOCKED);
							end else if (core_lock) begin
								next_st = fail(st, `RCC_ERR_DENIED);
							end else if (link.busy || dma_busy) begin
								next_st = fail(st, `RCC_ERR_BUSY);
							end else if (ext_addr_denied && launch_kind == RCC_SPI_WRITE) begin
								next_st = fail(st, `RCC_ERR_DENIED);
							end else if (ext_block_locked && launch_kind == RCC_SPI_WRITE) begin
								next_st = fail(st, `RCC_ERR_BLK_LOCKED);
							end else begin
								launch_start = 1'b1;
								next_st.spi_write = (launch_kind != RCC_SPI_RSTAT);
								next_st.state = RCC_SPI_WAIT;
							end
						end
						`RCC_OP_LOCK_DEV: begin
							if (!req_format_ok) begin
								next_st = fail(st, `RCC_ERR_FORMAT);
							end else begin
								next_st = pass(st);
								next_st.locked = 1'b1;
							end
						end
						`RCC_OP_UNLOCK_DEV: begin
							if (!req_format_ok) begin
								next_st = fail(st, `RCC_ERR_FORMAT);
							end else if (!pw_ok) begin
								next_st = fail(st, `RCC_ERR_DENIED);
							end else begin
								next_st = pass(st);
								next_st.locked = 1'b0;
							end
						end
						`RCC_OP_UPD_RF: begin
							if (!req_format_ok) begin
								next_st = fail(st, `RCC_ERR_FORMAT);
							end else if (st.locked) begin
								next_st = fail(st, `RCC_ERR_DEV_LOCKED);
							end else if (core_lock) begin
								next_st = fail(st, `RCC_ERR_DENIED);
							end else if (dma_busy || link.busy) begin
								next_st = fail(st, `RCC_ERR_BUSY);
							end else begin
								next_st.dma_go = 1'b1;
								next_st.state = RCC_DMA_WAIT;
							end
						end
						`RCC_OP_LOCK_PG: begin
							if (!req_format_ok) begin
								next_st = fail(st, `RCC_ERR_FORMAT);
							end else if (!page_ok) begin
								next_st = fail(st, `RCC_ERR_NO_BLOCK);
							end else if (st.locked) begin
								next_st = fail(st, `RCC_ERR_DEV_LOCKED);
							end else if (st.pages[page_idx]) begin
								next_st = fail(st, `RCC_ERR_ALR_LOCKED);
							end else begin
								next_st = pass(st);
								next_st.pages[page_idx] = 1'b1;
							end
						end
						`RCC_OP_UNLOCK_PG: begin
							if (!req_format_ok) begin
								next_st = fail(st, `RCC_ERR_FORMAT);
							end else if (!page_ok) begin
								next_st = fail(st, `RCC_ERR_NO_BLOCK);
							end else if (!pw_ok) begin
								next_st = fail(st, `RCC_ERR_DENIED);
							end else begin
								next_st = pass(st);
								next_st.pages[page_idx] = 1'b0;
							end
						end
						default: begin
							next_st = fail(st, `RCC_ERR_NOT_SUPP);
						end
					endcase
				end
			end
			RCC_SPI_WAIT: begin
				if (link.done) begin
					next_st = pass(st);
					next_st.state = RCC_IDLE;
					if (!st.spi_write) begin
						next_st.has_data = 1'b1;
						next_st.data = link.rdata;
					end
				end
			end
			RCC_DMA_WAIT: begin
				if (dma_done) begin
					next_st = pass(st);
					next_st.state = RCC_IDLE;
				end
			end
			default: begin
				next_st = fail(st, `RCC_ERR_UNKNOWN);
				next_st.state = RCC_IDLE;
			end
		endcase
	end
	always_ff @(posedge clk) begin
		if (reset) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	// SPI request fields from the frame; status write keeps only the low data byte
	assign link.start = launch_start;
	assign link.kind = launch_kind;
	assign link.opcode = req_opcode;
	assign link.addr = req_addr;
	assign link.data = (launch_kind == RCC_SPI_WSTAT) ? {8'h00, req_data[7:0]} : req_data;
	rcc_spi_launch u_launch (
		.clk(clk),
		.reset(reset),
		.link(link.launch),
		.spi_req(spi_req),
		.spi_kind(spi_kind),
		.spi_opcode(spi_opcode),
		.spi_addr(spi_addr),
		.spi_wdata(spi_wdata),
		.spi_done(spi_done),
		.spi_rdata(spi_rdata)
	);
	assign dma_start = st.dma_go;
	assign device_locked = st.locked;
	assign page_locked = st.pages;
	assign req_pending = (st.state != RCC_IDLE);
	assign resp_valid = st.resp_v;
	assign resp_flags = st.flags;
	assign resp_error = st.err;
	assign resp_has_data = st.has_data;
	assign resp_data = st.data;
endmodule : rcc_cmd_handler

// >>> bench/rcc_cmd_handler_checker.sv
// Purpose: Port assertions for the command handler
// Assumes: One clock, synchronous reset
// Notes: Bound to the handler
`timescale 1ns/1ps
`include "rcc_consts.svh"
module rcc_cmd_handler_checker
	import rcc_pkg::*;
(
	input wire logic clk,
	input wire logic reset,
	input wire logic req_valid,
	input wire logic [15:0] req_code,
	input wire logic [7:0] req_flags,
	input wire logic req_crc_ok,
	input wire logic req_format_ok,
	input wire logic [15:0] req_password,
	input wire logic [15:0] eeprom_password,
	input wire logic core_lock,
	input wire logic dma_busy,
	input wire logic dma_done,
	input wire logic dma_start,
	input wire logic device_locked,
	input wire logic req_pending,
	input wire logic resp_valid,
	input wire logic [7:0] resp_flags,
	input wire logic [7:0] resp_error,
	input wire logic resp_has_data,
	input wire logic [7:0] resp_data,
	input wire logic spi_req,
	input rcc_spi_kind_e spi_kind,
	input wire logic [15:0] spi_addr,
	input wire logic [15:0] spi_wdata,
	input wire logic spi_done,
	input wire logic [7:0] spi_rdata
);
	logic take;
	logic plain;
	assign take = req_valid & req_crc_ok & ~req_pending;
	assign plain = take & req_format_ok & ~req_flags[`RCC_FLAGS_OPT_BIT];
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	////////////////////////////////////////////////////////////////////////////////
	AST_SPI_RSP: assert property (spi_req && spi_done |-> ##2 resp_valid && !resp_flags)
		else $error("No good answer after SPI end");
	AST_RSTAT_DATA: assert property (
		spi_req && spi_done && spi_kind == RCC_SPI_RSTAT
		|-> ##2 resp_has_data && resp_data == $past(spi_rdata, 2))
		else $error("Status byte not returned");
	AST_SPI_HOLD: assert property (
		spi_req && !spi_done |=> spi_req && $stable(spi_addr) && $stable(spi_wdata))
		else $error("SPI request changed early");
	AST_ERR_CODE: assert property (resp_valid && resp_flags[0] |-> resp_error != 8'h00)
		else $error("Error answer without code");
	AST_PEND: assert property (spi_req |-> req_pending)
		else $error("SPI busy but not pending");
	AST_CRC_DROP: assert property (
		req_valid && !req_crc_ok && !req_pending |-> ##1 !resp_valid ##1 !resp_valid)
		else $error("Bad CRC request answered");
	AST_LOCK_DEV: assert property (plain && req_code == `RCC_OP_LOCK_DEV |-> ##[1:2] device_locked)
		else $error("Device not locked");
	AST_UNLOCK_BAD: assert property (
		take && req_code == `RCC_OP_UNLOCK_DEV && req_password != eeprom_password
		&& device_locked |=> device_locked [*2])
		else $error("Unlocked with wrong password");
	AST_CORE_LOCK: assert property (take && core_lock |=> (!spi_req && !dma_start) [*3])
		else $error("Work started under core lock");
	AST_DMA_START: assert property (
		plain && req_code == `RCC_OP_UPD_RF && !core_lock && !device_locked && !dma_busy
		|-> ##[1:2] dma_start)
		else $error("Update did not start DMA");
	AST_DMA_RSP: assert property (dma_done && req_pending |=> resp_valid)
		else $error("No answer after DMA end");
	COV_RSTAT: cover property (spi_done && spi_kind == RCC_SPI_RSTAT);
	COV_DMA: cover property (dma_done && req_pending);
	COV_ERR: cover property (resp_valid && resp_flags[0]);
endmodule : rcc_cmd_handler_checker

bind rcc_cmd_handler rcc_cmd_handler_checker i_chk (.clk, .reset, .req_valid, .req_code,
	.req_flags, .req_crc_ok, .req_format_ok, .req_password, .eeprom_password, .core_lock,
	.dma_busy, .dma_done, .dma_start, .device_locked, .req_pending, .resp_valid, .resp_flags,
	.resp_error, .resp_has_data, .resp_data, .spi_req, .spi_kind, .spi_addr, .spi_wdata,
	.spi_done, .spi_rdata);

// >>> bench/rcc_spi_model.sv
// Purpose: External SPI engine stand-in
// Assumes: Request held until done
// Notes: Done on the dly+1th request cycle with data RDATA; data loads 8'h3C in reset, RDATA with done, and toggles on all other cycles
`timescale 1ns/1ps
module rcc_spi_model #(
	parameter logic [7:0] RDATA = 8'h5A
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic spi_req,
	input wire logic [7:0] dly,
	output logic spi_done,
	output logic [7:0] spi_rdata
);
	logic [7:0] cnt;
	always @(posedge clk) begin
		spi_done <= 1'b0;
		spi_rdata <= ~spi_rdata;
		if (reset) begin
			cnt <= 8'h00;
			spi_rdata <= 8'h3C;
		end else if (spi_req && !spi_done) begin
			if (cnt >= dly) begin
				spi_done <= 1'b1;
				spi_rdata <= RDATA;
				cnt <= 8'h00;
			end else begin
				cnt <= cnt + 8'h01;
			end
		end
	end
endmodule : rcc_spi_model

// >>> bench/rcc_cmd_handler_test.sv
// Purpose: Self-checking bench for the command handler
// Assumes: 100 MHz clock, model answers SPI
// Notes: Error table, SPI table, locks, DMA
`timescale 1ns/1ps
`include "rcc_consts.svh"
module rcc_cmd_handler_test
	import rcc_pkg::*;
;
	logic clk, reset, req_valid, req_crc_ok, req_format_ok, core_lock, dma_busy, dma_done;
	logic ext_mem_present, ext_addr_denied, ext_block_locked;
	logic [15:0] req_code, req_addr, req_data, req_password, eeprom_password;
	logic [7:0] req_flags, req_opcode, req_page, dly;
	logic dma_start, device_locked, req_pending, resp_valid, resp_has_data, spi_req, spi_done;
	logic [`RCC_PAGES-1:0] page_locked;
	logic [7:0] resp_flags, resp_error, resp_data, spi_opcode, spi_rdata, cap_op;
	rcc_spi_kind_e spi_kind, cap_kind;
	logic [15:0] spi_addr, spi_wdata, cap_addr, cap_wdata;
	int err_count, tests_run;
	rcc_cmd_handler i_dut (.*);
	rcc_spi_model i_spi (.*);
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk) begin
		if (spi_req === 1'b1) begin
			cap_kind <= spi_kind;
			cap_op <= spi_opcode;
			cap_addr <= spi_addr;
			cap_wdata <= spi_wdata;
		end
	end
	task automatic finish_test();
		$display("Comparisons %0d, mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : finish_test
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp) begin
			err_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		chk({8'h00, got}, {8'h00, exp});
	endtask : chk8
	task automatic send(input logic [15:0] code);
		@(posedge clk);
		req_code <= code;
		req_valid <= 1'b1;
		@(posedge clk);
		req_valid <= 1'b0;
	endtask : send
	task automatic wait_resp(input logic [7:0] err);
		int n;
		for (n = 0; n < 300; n++) begin
			#1;
			if (resp_valid === 1'b1) break;
			@(posedge clk);
		end
		if (n == 300) begin
			chk8(8'(resp_valid), 8'h01);
			finish_test();
		end else begin
			chk8(resp_flags, (err == 8'h00) ? `RCC_FLAGS_OK : `RCC_FLAGS_ERR);
			if (err != 8'h00) chk8(resp_error, err);
			@(posedge clk);
		end
	endtask : wait_resp
	task automatic run(input logic [15:0] code, input logic [7:0] err);
		send(code);
		wait_resp(err);
	endtask : run
	task automatic quiet(input int cycles);
		int hits;
		hits = 0;
		repeat (cycles) begin
			@(posedge clk);
			#1;
			hits += (resp_valid === 1'b1);
		end
		chk(16'(hits), 16'h0000);
		@(posedge clk);
	endtask : quiet
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		logic [7:0] errs [7];
		logic [15:0] ops [5];
		rcc_spi_kind_e kinds [5];
		int n;
		errs = '{`RCC_ERR_FORMAT, `RCC_ERR_OPTION, `RCC_ERR_NO_BLOCK, `RCC_ERR_DENIED,
			`RCC_ERR_BUSY, `RCC_ERR_DENIED, `RCC_ERR_BLK_LOCKED};
		ops = '{`RCC_OP_WR_EXT, `RCC_OP_SEND_CMD, `RCC_OP_ADDR_CMD, `RCC_OP_WR_STAT,
			`RCC_OP_RD_STAT};
		kinds = '{RCC_SPI_WRITE, RCC_SPI_OPCODE, RCC_SPI_ADDR, RCC_SPI_WSTAT, RCC_SPI_RSTAT};
		{req_valid, core_lock, dma_busy, dma_done, ext_addr_denied, ext_block_locked} = '0;
		{req_crc_ok, req_format_ok, ext_mem_present, reset} = 4'hF;
		{req_code, req_flags, req_page, dly} = '0;
		req_addr = 16'h0F3C;
		req_data = 16'hA55A;
		req_opcode = 8'h06;
		req_password = 16'h0BAD;
		eeprom_password = 16'hC0DE;
		repeat (16) @(posedge clk);
		reset <= 1'b0;
		run(16'h1234, `RCC_ERR_NOT_SUPP);
		for (int i = 0; i < 7; i++) begin
			req_format_ok <= (i != 0);
			req_flags <= (i == 1) ? 8'h40 : 8'h00;
			ext_mem_present <= (i != 2);
			core_lock <= (i == 3);
			dma_busy <= (i == 4);
			ext_addr_denied <= (i == 5);
			ext_block_locked <= (i == 6);
			run(`RCC_OP_WR_EXT, errs[i]);
			if (i == 4) begin
				run(`RCC_OP_RD_STAT, `RCC_ERR_BUSY);
				dma_busy <= 1'b0;
				repeat (3) @(posedge clk);
				run(`RCC_OP_WR_EXT, 8'h00);
				chk(16'(cap_kind), 16'(RCC_SPI_WRITE));
			end
		end
		{req_format_ok, ext_mem_present, core_lock, dma_busy, ext_block_locked} <= 5'h18;
		for (int i = 0; i < 5; i++) begin
			dly <= 8'(i * 7);
			run(ops[i], 8'h00);
			chk(16'(cap_kind), 16'(kinds[i]));
			if (i != 0) chk8(cap_op, req_opcode);
			if (i == 0 || i == 2) chk(cap_addr, req_addr);
			if (i == 0) chk(cap_wdata, req_data);
			if (i == 3) chk8(cap_wdata[7:0], req_data[7:0]);
			if (i == 4) chk8(resp_data, 8'h5A);
			chk8(8'(resp_has_data), 8'(i == 4));
		end
		dly <= 8'd40;
		send(`RCC_OP_WR_EXT);
		repeat (4) @(posedge clk);
		chk8(8'(req_pending), 8'h01);
		send(`RCC_OP_SEND_CMD);
		wait_resp(8'h00);
		chk(16'(cap_kind), 16'(RCC_SPI_WRITE));
		quiet(50);
		req_crc_ok <= 1'b0;
		send(`RCC_OP_LOCK_DEV);
		quiet(8);
		chk8(8'(device_locked), 8'h00);
		req_crc_ok <= 1'b1;
		run(`RCC_OP_LOCK_DEV, 8'h00);
		run(`RCC_OP_WR_EXT, `RCC_ERR_DEV_LOCKED);
		run(`RCC_OP_UNLOCK_DEV, `RCC_ERR_DENIED);
		chk8(8'(device_locked), 8'h01);
		req_password <= eeprom_password;
		run(`RCC_OP_UNLOCK_DEV, 8'h00);
		chk8(8'(device_locked), 8'h00);
		req_page <= 8'd3;
		run(`RCC_OP_LOCK_PG, 8'h00);
		chk8(page_locked, 8'h08);
		run(`RCC_OP_LOCK_PG, `RCC_ERR_ALR_LOCKED);
		req_page <= 8'd8;
		run(`RCC_OP_LOCK_PG, `RCC_ERR_NO_BLOCK);
		req_page <= 8'd3;
		req_password <= 16'h0BAD;
		run(`RCC_OP_UNLOCK_PG, `RCC_ERR_DENIED);
		chk8(page_locked, 8'h08);
		req_password <= eeprom_password;
		run(`RCC_OP_UNLOCK_PG, 8'h00);
		chk8(page_locked, 8'h00);
		send(`RCC_OP_UPD_RF);
		for (n = 0; n < 20; n++) begin
			#1;
			if (dma_start === 1'b1) break;
			@(posedge clk);
		end
		chk8(8'(dma_start), 8'h01);
		@(posedge clk);
		dma_done <= 1'b1;
		@(posedge clk);
		dma_done <= 1'b0;
		wait_resp(8'h00);
		finish_test();
	end
endmodule : rcc_cmd_handler_test
